// *** verilog/debug_link_pkg.sv ***
/*
  constants, encodings and state types of the two-wire debug and
  programming link register layer.
  assumes every user names items as debug_link_pkg::name.
*/
// Overview of operation
// - the host drives the link clock and both sides move bits on one shared data line.
// - an 8-bit target select loaded over the link chooses the data register used next.
// - with target select at 0x00 a data read returns the part identifier.
// - with target select at 0x01 a data read returns the silicon revision.
// - with target select at 0x02 data reads and writes reach programming-control.
// - with target select at 0xb4 data reads and writes reach programming-data.
// - the silicon revision is an 8-bit code fixed by the die, not by reset.
// - programming opens only after 0x02 and then 0x01 are written to programming-control.
// - once open, programming stays open until a system reset.
// - these registers are reached only by link transactions and flash loads into programming-data, never by the processor.
// - programming-data carries addresses, data and commands 0x06, 0x07, 0x08 and 0x03.
// - link traffic normally runs with the core halted so the link may borrow shared pins.
package debug_link_pkg;

   // target select values
   localparam logic [7:0] ADDR_PART_ID      = 8'h00;
   localparam logic [7:0] ADDR_REVISION     = 8'h01;
   localparam logic [7:0] ADDR_PROG_CONTROL = 8'h02;
   localparam logic [7:0] ADDR_PROG_DATA    = 8'hb4;
   localparam logic [7:0] ADDR_PART_ID_ALT  = 8'hfd;
   localparam logic [7:0] ADDR_REVISION_ALT = 8'hfe;

   // reset values
   localparam logic [7:0] RST_TARGET_SELECT = 8'h00;
   localparam logic [7:0] RST_PROG_CONTROL  = 8'h00;
   localparam logic [7:0] RST_PROG_DATA     = 8'h00;
   localparam logic [7:0] RST_WORD          = 8'h00;

   // arbitrary value, no meaning beyond this model
   localparam logic [7:0] PART_ID_CODE      = 8'h5a;

   // unlock pair
   localparam logic [7:0] UNLOCK_FIRST      = 8'h02;
   localparam logic [7:0] UNLOCK_SECOND     = 8'h01;

   // flash command codes
   localparam logic [7:0] CMD_BLOCK_READ    = 8'h06;
   localparam logic [7:0] CMD_BLOCK_WRITE   = 8'h07;
   localparam logic [7:0] CMD_PAGE_ERASE    = 8'h08;
   localparam logic [7:0] CMD_DEVICE_ERASE  = 8'h03;

   // link instruction codes, bit 0 sent first
   localparam logic [1:0] INS_DATA_READ     = 2'h0;
   localparam logic [1:0] INS_DATA_WRITE    = 2'h1;
   localparam logic [1:0] INS_ADDR_READ     = 2'h2;
   localparam logic [1:0] INS_ADDR_WRITE    = 2'h3;
   localparam int         INS_WRITE_BIT     = 0;
   localparam int         INS_ADDR_BIT      = 1;

   // bit counts on the link
   localparam logic [3:0] INS_LAST_BIT      = 4'h1;
   localparam logic [3:0] WORD_LAST_BIT     = 4'h7;
   localparam logic [3:0] CNT_ZERO          = 4'h0;
   localparam logic [3:0] CNT_ONE           = 4'h1;

   typedef enum logic [2:0] {
      LS_IDLE,
      LS_INS,
      LS_WDATA,
      LS_WAIT,
      LS_RDATA,
      LS_STOP
   } link_state_t;

   typedef enum logic [1:0] {
      LOCK_IDLE,
      LOCK_GOT_FIRST,
      LOCK_OPEN
   } lock_state_t;

endpackage

// *** verilog/cdc_sync.sv ***
/*
  three-stage synchroniser for levels and toggles entering a clock domain.
  assumes its input changes slowly against the receiving clock.
*/
module cdc_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         srst,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] q_ff;
   logic [W-1:0] nxt_q;

   // first stage feeds the second only; a value counts once stages two and three agree
   always_comb
   begin
      nxt_q = q_ff;
      for (int i = 0; i < W; i++)
      begin
         if (s2_ff[i] == s3_ff[i])
         begin
            nxt_q[i] = s3_ff[i];
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         q_ff  <= '0;
      end
      else if (ce)
      begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff  <= nxt_q;
      end
   end

   assign q = q_ff;

endmodule

// *** verilog/debug_link_regs.sv ***
/*
  register layer behind the two-wire debug link: link-side shifter on the
  host clock, target select, identifier, revision, programming-control
  with its unlock sequence and programming-data with command capture.
  assumes the host clock stands still between frames, the host keeps
  clocking through wait bits, and the revision pins are tied per die.
*/
module debug_link_regs (
   input  wire logic       clock,
   input  wire logic       srst,
   input  wire logic       ce,
   input  wire logic       link_clock_line,
   input  wire logic       link_data_in,
   output logic            link_data_out,
   output logic            link_data_oe,
   input  wire logic [7:0] revision_code,
   input  wire logic       core_halted,
   input  wire logic       flash_done,
   input  wire logic       flash_load,
   input  wire logic [7:0] flash_byte,
   output logic            prog_enable,
   output logic [7:0]      prog_byte,
   output logic            prog_byte_strobe,
   output logic            cmd_strobe,
   output logic [7:0]      cmd_code
);

   // link domain state
   logic [1:0]                  lctl;
   logic                        lsrst;
   logic                        lce;
   logic                        ack_sync;
   debug_link_pkg::link_state_t lstate_ff;
   debug_link_pkg::link_state_t nxt_lstate;
   logic [3:0]                  lcnt_ff;
   logic [3:0]                  nxt_lcnt;
   logic [1:0]                  lins_ff;
   logic [1:0]                  nxt_lins;
   logic [7:0]                  lword_ff;
   logic [7:0]                  nxt_lword;
   logic                        req_ff;
   logic                        nxt_req;
   logic                        ack_seen_ff;
   logic                        nxt_ack_seen;
   logic                        dout_ff;
   logic                        nxt_dout;
   logic                        doe_ff;
   logic                        nxt_doe;

   // core domain state
   logic                        req_sync;
   logic                        req_seen_ff;
   logic                        ack_ff;
   logic [7:0]                  rd_word_ff;
   logic [7:0]                  target_ff;
   logic [7:0]                  prog_control_ff;
   logic [7:0]                  prog_data_ff;
   debug_link_pkg::lock_state_t lock_ff;
   logic                        expect_cmd_ff;
   logic                        enable_ff;
   logic [7:0]                  pbyte_ff;
   logic                        pstrobe_ff;
   logic                        cstrobe_ff;
   logic [7:0]                  ccode_ff;
   logic                        serve;
   logic                        is_write;
   logic                        is_addr;
   logic [7:0]                  sel_word;
   logic                        nxt_req_seen;
   logic                        nxt_ack;
   logic [7:0]                  nxt_rd_word;
   logic [7:0]                  nxt_target;
   logic [7:0]                  nxt_prog_control;
   logic [7:0]                  nxt_prog_data;
   debug_link_pkg::lock_state_t nxt_lock;
   logic                        nxt_expect_cmd;
   logic                        nxt_enable;
   logic [7:0]                  nxt_pbyte;
   logic                        nxt_pstrobe;
   logic                        nxt_cstrobe;
   logic [7:0]                  nxt_ccode;

   // reset and clock enable reach the link clock through the synchroniser
   cdc_sync #(.W(2)) u_lctl_sync (
      .clock (link_clock_line),
      .srst  (1'b0),
      .ce    (1'b1),
      .d     ({srst, ce}),
      .q     (lctl)
   );
   assign lsrst = lctl[1];
   assign lce   = lctl[0];

   cdc_sync #(.W(1)) u_ack_sync (
      .clock (link_clock_line),
      .srst  (lsrst),
      .ce    (lce),
      .d     (ack_ff),
      .q     (ack_sync)
   );

   cdc_sync #(.W(1)) u_req_sync (
      .clock (clock),
      .srst  (srst),
      .ce    (ce),
      .d     (req_ff),
      .q     (req_sync)
   );

   // link framing: start bit, two instruction bits, optional write byte,
   // wait bits until the core answers, ready bit, optional read byte
   always_comb
   begin
      nxt_lstate   = lstate_ff;
      nxt_lcnt     = lcnt_ff;
      nxt_lins     = lins_ff;
      nxt_lword    = lword_ff;
      nxt_req      = req_ff;
      nxt_ack_seen = ack_seen_ff;
      nxt_dout     = 1'b0;
      nxt_doe      = 1'b0;
      case (lstate_ff)
         debug_link_pkg::LS_IDLE:
         begin
            if (link_data_in)
            begin
               nxt_lstate = debug_link_pkg::LS_INS;
               nxt_lcnt   = debug_link_pkg::CNT_ZERO;
            end
         end
         debug_link_pkg::LS_INS:
         begin
            nxt_lins = {link_data_in, lins_ff[1]};
            nxt_lcnt = lcnt_ff + debug_link_pkg::CNT_ONE;
            if (lcnt_ff == debug_link_pkg::INS_LAST_BIT)
            begin
               nxt_lcnt = debug_link_pkg::CNT_ZERO;
               if (link_data_in == 1'b1 && lins_ff[1] == 1'b1)
               begin
                  nxt_lstate = debug_link_pkg::LS_WDATA;
               end
               else if (lins_ff[1] == 1'b1)
               begin
                  nxt_lstate = debug_link_pkg::LS_WDATA;
               end
               else
               begin
                  nxt_req    = ~req_ff;
                  nxt_lstate = debug_link_pkg::LS_WAIT;
                  nxt_doe    = 1'b1;
               end
            end
         end
         debug_link_pkg::LS_WDATA:
         begin
            nxt_lword = {link_data_in, lword_ff[7:1]};
            nxt_lcnt  = lcnt_ff + debug_link_pkg::CNT_ONE;
            if (lcnt_ff == debug_link_pkg::WORD_LAST_BIT)
            begin
               nxt_req    = ~req_ff;
               nxt_lstate = debug_link_pkg::LS_WAIT;
               nxt_doe    = 1'b1;
            end
         end
         debug_link_pkg::LS_WAIT:
         begin
            nxt_doe = 1'b1;
            if (ack_sync != ack_seen_ff)
            begin
               nxt_ack_seen = ack_sync;
               nxt_dout     = 1'b1;
               nxt_lcnt     = debug_link_pkg::CNT_ZERO;
               nxt_lword    = rd_word_ff;
               nxt_lstate   = lins_ff[debug_link_pkg::INS_WRITE_BIT] ?
                              debug_link_pkg::LS_STOP : debug_link_pkg::LS_RDATA;
            end
         end
         debug_link_pkg::LS_RDATA:
         begin
            nxt_doe   = 1'b1;
            nxt_dout  = lword_ff[0];
            nxt_lword = {1'b0, lword_ff[7:1]};
            nxt_lcnt  = lcnt_ff + debug_link_pkg::CNT_ONE;
            if (lcnt_ff == debug_link_pkg::WORD_LAST_BIT)
            begin
               nxt_lstate = debug_link_pkg::LS_STOP;
            end
         end
         debug_link_pkg::LS_STOP:
         begin
            nxt_lstate = debug_link_pkg::LS_IDLE;
         end
         default:
         begin
            nxt_lstate = debug_link_pkg::LS_IDLE;
         end
      endcase
   end

   always_ff @(posedge link_clock_line)
   begin
      if (lsrst)
      begin
         lstate_ff   <= debug_link_pkg::LS_IDLE;
         lcnt_ff     <= debug_link_pkg::CNT_ZERO;
         lins_ff     <= debug_link_pkg::INS_DATA_READ;
         lword_ff    <= debug_link_pkg::RST_WORD;
         req_ff      <= 1'b0;
         ack_seen_ff <= 1'b0;
         dout_ff     <= 1'b0;
         doe_ff      <= 1'b0;
      end
      else if (lce)
      begin
         lstate_ff   <= nxt_lstate;
         lcnt_ff     <= nxt_lcnt;
         lins_ff     <= nxt_lins;
         lword_ff    <= nxt_lword;
         req_ff      <= nxt_req;
         ack_seen_ff <= nxt_ack_seen;
         dout_ff     <= nxt_dout;
         doe_ff      <= nxt_doe;
      end
   end

   // core side: lins_ff and lword_ff hold still until the ack returns, so a
   // synchronised toggle is enough to read them safely
   assign serve    = req_sync != req_seen_ff;
   assign is_write = lins_ff[debug_link_pkg::INS_WRITE_BIT];
   assign is_addr  = lins_ff[debug_link_pkg::INS_ADDR_BIT];

   // read mux; unmapped targets read as zero
   always_comb
   begin
      case (target_ff)
         debug_link_pkg::ADDR_PART_ID,
         debug_link_pkg::ADDR_PART_ID_ALT:  sel_word = debug_link_pkg::PART_ID_CODE;
         debug_link_pkg::ADDR_REVISION,
         debug_link_pkg::ADDR_REVISION_ALT: sel_word = revision_code;
         debug_link_pkg::ADDR_PROG_CONTROL: sel_word = prog_control_ff;
         debug_link_pkg::ADDR_PROG_DATA:    sel_word = prog_data_ff;
         default:                           sel_word = 8'h00;
      endcase
   end

   // only link transactions and flash loads into programming-data reach these registers, no processor port
   always_comb
   begin
      nxt_req_seen     = req_seen_ff;
      nxt_ack          = ack_ff;
      nxt_rd_word      = rd_word_ff;
      nxt_target       = target_ff;
      nxt_prog_control = prog_control_ff;
      nxt_prog_data    = prog_data_ff;
      nxt_lock         = lock_ff;
      nxt_expect_cmd   = expect_cmd_ff;
      nxt_pbyte        = pbyte_ff;
      nxt_pstrobe      = 1'b0;
      nxt_cstrobe      = 1'b0;
      nxt_ccode        = ccode_ff;
      if (flash_load)
      begin
         nxt_prog_data = flash_byte;
      end
      if (serve)
      begin
         nxt_req_seen = req_sync;
         nxt_ack      = ~ack_ff;
         nxt_rd_word  = is_addr ? target_ff : sel_word;
         if (is_write && is_addr)
         begin
            nxt_target = lword_ff;
         end
         else if (is_write && target_ff == debug_link_pkg::ADDR_PROG_CONTROL)
         begin
            nxt_prog_control = lword_ff;
            case (lock_ff)
               debug_link_pkg::LOCK_OPEN:
                  nxt_lock = debug_link_pkg::LOCK_OPEN;
               debug_link_pkg::LOCK_GOT_FIRST:
                  nxt_lock = (lword_ff == debug_link_pkg::UNLOCK_SECOND) ?
                             debug_link_pkg::LOCK_OPEN :
                             (lword_ff == debug_link_pkg::UNLOCK_FIRST) ?
                             debug_link_pkg::LOCK_GOT_FIRST : debug_link_pkg::LOCK_IDLE;
               default:
                  nxt_lock = (lword_ff == debug_link_pkg::UNLOCK_FIRST) ?
                             debug_link_pkg::LOCK_GOT_FIRST : debug_link_pkg::LOCK_IDLE;
            endcase
         end
         else if (is_write && target_ff == debug_link_pkg::ADDR_PROG_DATA)
         begin
            // a write here beats a flash load in the same cycle
            nxt_prog_data = lword_ff;
            if (lock_ff == debug_link_pkg::LOCK_OPEN && core_halted)
            begin
               nxt_pbyte   = lword_ff;
               nxt_pstrobe = 1'b1;
               if (expect_cmd_ff &&
                   (lword_ff == debug_link_pkg::CMD_BLOCK_READ  ||
                    lword_ff == debug_link_pkg::CMD_BLOCK_WRITE ||
                    lword_ff == debug_link_pkg::CMD_PAGE_ERASE  ||
                    lword_ff == debug_link_pkg::CMD_DEVICE_ERASE))
               begin
                  nxt_ccode      = lword_ff;
                  nxt_cstrobe    = 1'b1;
                  nxt_expect_cmd = 1'b0;
               end
            end
         end
         // writes to identifier or revision fall through untouched
      end
      // re-arm wins over a capture in the same cycle, so no command is lost
      if (flash_done)
      begin
         nxt_expect_cmd = 1'b1;
      end
      nxt_enable = nxt_lock == debug_link_pkg::LOCK_OPEN;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         req_seen_ff     <= 1'b0;
         ack_ff          <= 1'b0;
         rd_word_ff      <= debug_link_pkg::RST_WORD;
         target_ff       <= debug_link_pkg::RST_TARGET_SELECT;
         prog_control_ff <= debug_link_pkg::RST_PROG_CONTROL;
         prog_data_ff    <= debug_link_pkg::RST_PROG_DATA;
         lock_ff         <= debug_link_pkg::LOCK_IDLE;
         expect_cmd_ff   <= 1'b1;
         enable_ff       <= 1'b0;
         pbyte_ff        <= debug_link_pkg::RST_WORD;
         pstrobe_ff      <= 1'b0;
         cstrobe_ff      <= 1'b0;
         ccode_ff        <= debug_link_pkg::RST_WORD;
      end
      else if (ce)
      begin
         req_seen_ff     <= nxt_req_seen;
         ack_ff          <= nxt_ack;
         rd_word_ff      <= nxt_rd_word;
         target_ff       <= nxt_target;
         prog_control_ff <= nxt_prog_control;
         prog_data_ff    <= nxt_prog_data;
         lock_ff         <= nxt_lock;
         expect_cmd_ff   <= nxt_expect_cmd;
         enable_ff       <= nxt_enable;
         pbyte_ff        <= nxt_pbyte;
         pstrobe_ff      <= nxt_pstrobe;
         cstrobe_ff      <= nxt_cstrobe;
         ccode_ff        <= nxt_ccode;
      end
   end

   assign link_data_out    = dout_ff;
   assign link_data_oe     = doe_ff;
   assign prog_enable      = enable_ff;
   assign prog_byte        = pbyte_ff;
   assign prog_byte_strobe = pstrobe_ff;
   assign cmd_strobe       = cstrobe_ff;
   assign cmd_code         = ccode_ff;

   AST_UNLOCK_OPENS: assert property (@(posedge clock) disable iff (srst)
      ce && serve && is_write && !is_addr && target_ff == debug_link_pkg::ADDR_PROG_CONTROL
      && lock_ff == debug_link_pkg::LOCK_GOT_FIRST && lword_ff == debug_link_pkg::UNLOCK_SECOND
      |=> prog_enable)
      else $error("unlock pair did not open programming");

   AST_NO_OPEN_WITHOUT_PAIR: assert property (@(posedge clock) disable iff (srst)
      $rose(prog_enable) |-> $past(lock_ff) == debug_link_pkg::LOCK_GOT_FIRST)
      else $error("programming opened without the first unlock code");

   AST_ENABLE_STICKY: assert property (@(posedge clock) disable iff (srst)
      prog_enable |=> prog_enable)
      else $error("programming closed without a system reset");

   AST_READ_PART_ID: assert property (@(posedge clock) disable iff (srst)
      ce && serve && !is_write && !is_addr && target_ff == debug_link_pkg::ADDR_PART_ID
      |=> rd_word_ff == debug_link_pkg::PART_ID_CODE && ack_ff != $past(ack_ff))
      else $error("part identifier read returned wrong value");

   AST_READ_REVISION: assert property (@(posedge clock) disable iff (srst)
      ce && serve && !is_write && !is_addr && target_ff == debug_link_pkg::ADDR_REVISION
      |=> rd_word_ff == $past(revision_code))
      else $error("revision read returned wrong value");

   AST_WRITE_PROG_CONTROL: assert property (@(posedge clock) disable iff (srst)
      ce && serve && is_write && !is_addr && target_ff == debug_link_pkg::ADDR_PROG_CONTROL
      |=> prog_control_ff == $past(lword_ff))
      else $error("programming-control write lost");

   AST_WRITE_PROG_DATA: assert property (@(posedge clock) disable iff (srst)
      ce && serve && is_write && !is_addr && target_ff == debug_link_pkg::ADDR_PROG_DATA
      |=> prog_data_ff == $past(lword_ff))
      else $error("programming-data write lost");

   AST_ADDR_LOAD: assert property (@(posedge clock) disable iff (srst)
      ce && serve && is_write && is_addr |=> target_ff == $past(lword_ff) ##1 $stable(target_ff))
      else $error("target select not loaded");

   AST_ID_WRITE_IGNORED: assert property (@(posedge clock) disable iff (srst)
      serve && is_write && !is_addr && target_ff == debug_link_pkg::ADDR_PART_ID && !flash_load
      |=> $stable(prog_control_ff) && $stable(prog_data_ff) && $stable(lock_ff))
      else $error("identifier write changed a register");

   AST_LINK_DRIVES_READ: assert property (@(posedge link_clock_line) disable iff (lsrst)
      lce && lstate_ff == debug_link_pkg::LS_RDATA |=> link_data_oe)
      else $error("data line not driven during a read byte");

endmodule

// *** verification/link_host.sv ***
/*
  behavioural host adapter for the two-wire debug link.
  assumes the bench resolves the data line from the target's enable alone.
*/
module link_host (
   output logic      link_clock_line,
   output logic      host_drive,
   input  wire logic link_data_out,
   input  wire logic link_data_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      link_clock_line = 1'b0;
      host_drive      = 1'b0;
   end
   // clock stands still between frames; data changes only after a fall
   task automatic tick(input logic d);
      host_drive <= d;
      #41.3 link_clock_line <= 1'b1;
      #38.7 link_clock_line <= 1'b0;
   endtask
   task automatic frame(input logic [1:0] ins, input logic [7:0] wd,
                        output logic [7:0] rd, output logic ok);
      ok = 1'b0;
      rd = 8'h00;
      tick(1'b1);
      for (int i = 0; i < 2; i++) tick(ins[i]);
      if (ins[0] === 1'b1)
      begin
         for (int i = 0; i < 8; i++) tick(wd[i]);
      end
      // released line: inverse of last value, never a stale copy
      for (int n = 0; n < 40 && !ok; n++)
      begin
         tick(~host_drive);
         ok = (link_data_oe === 1'b1 && link_data_out === 1'b1);
      end
      if (ins[0] === 1'b0)
      begin
         for (int i = 0; i < 8; i++)
         begin
            tick(~host_drive);
            rd[i] = link_data_out;
         end
      end
      tick(1'b0);
      ok = ok && (link_data_oe === 1'b0);
   endtask
endmodule

// *** verification/tb.sv ***
/*
  self-checking bench for the debug link register layer.
  assumes link_host supplies the link clock only within frames and during do_reset.
*/
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] rev_code = 8'h3c;
   logic       clock, srst, core_halted, flash_done, flash_load, prog_enable;
   logic       link_clock_line, host_drive, link_data_out, link_data_oe;
   logic       prog_byte_strobe, cmd_strobe;
   logic [7:0] flash_byte, prog_byte, cmd_code, last_cmd, last_byte, d;
   int         failures, total_checks, n_cmd, n_byte, b;
   wire        data_wire = link_data_oe ? link_data_out : host_drive;
   debug_link_regs dut (.clock(clock), .srst(srst), .ce(1'b1),
      .link_clock_line(link_clock_line), .link_data_in(data_wire),
      .link_data_out(link_data_out), .link_data_oe(link_data_oe),
      .revision_code(rev_code), .core_halted(core_halted), .flash_done(flash_done),
      .flash_load(flash_load), .flash_byte(flash_byte), .prog_enable(prog_enable),
      .prog_byte(prog_byte), .prog_byte_strobe(prog_byte_strobe),
      .cmd_strobe(cmd_strobe), .cmd_code(cmd_code));
   link_host host (.link_clock_line(link_clock_line), .host_drive(host_drive),
      .link_data_out(link_data_out), .link_data_oe(link_data_oe));
   always #2 clock = ~clock;
   always @(posedge clock)
   begin
      if (cmd_strobe === 1'b1)
      begin
         n_cmd    <= n_cmd + 1;
         last_cmd <= cmd_code;
      end
      if (prog_byte_strobe === 1'b1)
      begin
         n_byte    <= n_byte + 1;
         last_byte <= prog_byte;
      end
   end
   task automatic conclude();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic xfer(input logic [1:0] ins, input logic [7:0] wd);
      logic ok;
      host.frame(ins, wd, d, ok);
      if (!ok)
      begin
         failures++;
         conclude();
      end
      repeat (4) @(posedge clock);
   endtask
   task automatic sel_rd(input logic [7:0] a);
      xfer(debug_link_pkg::INS_ADDR_WRITE, a);
      xfer(debug_link_pkg::INS_DATA_READ, 8'h00);
   endtask
   task automatic sel_wr(input logic [7:0] a, input logic [7:0] v);
      xfer(debug_link_pkg::INS_ADDR_WRITE, a);
      xfer(debug_link_pkg::INS_DATA_WRITE, v);
   endtask
   // link domain resets through its own flops, so the link must run meanwhile
   task automatic do_reset();
      @(posedge clock) srst <= 1'b1;
      repeat (5) @(posedge clock);
      for (int i = 0; i < 5; i++) host.tick(1'b0);
      @(posedge clock) srst <= 1'b0;
      for (int i = 0; i < 5; i++) host.tick(1'b0);
   endtask
   task automatic t_reset();
      xfer(debug_link_pkg::INS_ADDR_READ, 8'h00);
      chk("target_select", debug_link_pkg::RST_TARGET_SELECT, d);
      chk("prog_enable", 8'h00, {7'h00, prog_enable});
      sel_rd(debug_link_pkg::ADDR_PROG_CONTROL);
      chk("prog_control", debug_link_pkg::RST_PROG_CONTROL, d);
      xfer(debug_link_pkg::INS_ADDR_READ, 8'h00);
      chk("target_select", debug_link_pkg::ADDR_PROG_CONTROL, d);
      $display("test reset done");
   endtask
   task automatic t_ids();
      logic [7:0] addr [5];
      logic [7:0] want [5];
      addr = '{8'h00, 8'hfd, 8'h01, 8'hfe, 8'h33};
      want = '{debug_link_pkg::PART_ID_CODE, debug_link_pkg::PART_ID_CODE,
               rev_code, rev_code, 8'h00};
      for (int i = 0; i < 5; i++)
      begin
         sel_wr(addr[i], 8'hff);
         sel_rd(addr[i]);
         chk("ident", want[i], d);
      end
      $display("test ids done");
   endtask
   task automatic t_unlock();
      sel_wr(debug_link_pkg::ADDR_PROG_CONTROL, 8'h01);
      sel_wr(debug_link_pkg::ADDR_PROG_CONTROL, 8'h02);
      sel_wr(debug_link_pkg::ADDR_PROG_CONTROL, 8'h07);
      sel_wr(debug_link_pkg::ADDR_PROG_CONTROL, 8'h01);
      chk("prog_enable", 8'h00, {7'h00, prog_enable});
      sel_wr(debug_link_pkg::ADDR_PROG_CONTROL, 8'h02);
      sel_wr(debug_link_pkg::ADDR_PROG_CONTROL, 8'h01);
      chk("prog_enable", 8'h01, {7'h00, prog_enable});
      sel_rd(debug_link_pkg::ADDR_PROG_CONTROL);
      chk("prog_control", 8'h01, d);
      $display("test unlock done");
   endtask
   task automatic t_cmds();
      logic [7:0] code [4];
      code = '{8'h06, 8'h07, 8'h08, 8'h03};
      b = n_byte;
      sel_wr(debug_link_pkg::ADDR_PROG_DATA, code[0]);
      chk("byte_strobes", 8'h00, 8'(n_byte - b));
      @(posedge clock) core_halted <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clock) flash_done <= 1'b1;
         @(posedge clock) flash_done <= 1'b0;
         b = n_cmd;
         sel_wr(debug_link_pkg::ADDR_PROG_DATA, code[i]);
         chk("cmd_strobes", 8'h01, 8'(n_cmd - b));
         chk("cmd_code", code[i], last_cmd);
         chk("prog_byte", code[i], last_byte);
      end
      // after re-arm: an unknown code is passed on but not captured, one capture only
      @(posedge clock) flash_done <= 1'b1;
      @(posedge clock) flash_done <= 1'b0;
      b = n_cmd;
      sel_wr(debug_link_pkg::ADDR_PROG_DATA, 8'h55);
      chk("cmd_strobes", 8'h00, 8'(n_cmd - b));
      chk("prog_byte", 8'h55, last_byte);
      sel_wr(debug_link_pkg::ADDR_PROG_DATA, debug_link_pkg::CMD_PAGE_ERASE);
      sel_wr(debug_link_pkg::ADDR_PROG_DATA, debug_link_pkg::CMD_BLOCK_WRITE);
      chk("cmd_strobes", 8'h01, 8'(n_cmd - b));
      chk("cmd_code", debug_link_pkg::CMD_PAGE_ERASE, last_cmd);
      chk("prog_byte", debug_link_pkg::CMD_BLOCK_WRITE, last_byte);
      @(posedge clock)
      begin
         flash_byte <= 8'ha5;
         flash_load <= 1'b1;
      end
      @(posedge clock) flash_load <= 1'b0;
      sel_rd(debug_link_pkg::ADDR_PROG_DATA);
      chk("prog_data", 8'ha5, d);
      $display("test commands done");
   endtask
   task automatic t_sticky();
      sel_wr(debug_link_pkg::ADDR_PROG_CONTROL, 8'h00);
      chk("prog_enable", 8'h01, {7'h00, prog_enable});
      do_reset();
      chk("prog_enable", 8'h00, {7'h00, prog_enable});
      $display("test sticky done");
   endtask
   initial
   begin
      clock = 1'b0;
      srst = 1'b1;
      core_halted = 1'b0;
      flash_done = 1'b0;
      flash_load = 1'b0;
      flash_byte = 8'h00;
      failures = 0;
      total_checks = 0;
      n_cmd = 0;
      n_byte = 0;
      do_reset();
      t_reset();
      t_ids();
      t_unlock();
      t_cmds();
      t_sticky();
      conclude();
   end
endmodule
